// File: pkg/cmt_map.svh
// Purpose: Constants for the core timing and memory-space decoder.
// Assumes: 40 MHz ref_clk used as the oscillator input.
// Notes: Addresses are 16-bit byte addresses.
//
// Summary of operation
// - Oscillator is divided by three into internal phases A, B and C.
// - One state time equals three oscillator periods; each phase once per state.
// - Each phase has one-third duty; only phase A leaves on the clock pin.
// - Active-low reset restarts the phase sequence at a defined time.
// - Full 64 KB space is decoded; ordinary locations go external.
// - Data to 0x00-0xFF goes to registers; fetches there go external.
// - Nonmaskable interrupt forces a call to external address 0x0000.
// - 0x1FFE and 0x1FFF are port reconstruction locations, else ordinary external.
// - Nine interrupt vectors sit at 0x2000 through 0x2011.
// - 0x2012-0x2077 reserved internally for test code; usable externally.
// - After reset the first fetch address is 0x2080.
// - Internal ROM used only if fitted, select high, address 0x2000-0x3FFF.
// - Register file holds 232 bytes usable as byte, word or double word.
// - First register-file word is the stack pointer.
// - No accumulator; unit works directly on the 256-byte register space.
// - 16-bit bus carries register data; 8-bit bus carries addresses.
// - Shadow fetch counter tracks PC, reloads on jump; data fetches bypass it.
// - Reload plus first fetch of a new stream takes four state times.
// - PC has its own incrementer; jump targets pass through the unit.
// - 17-bit arithmetic unit and 5-bit loop counter for repeated shifts.
// - Second operand may be complemented into the B input for subtraction.
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH
`define CMT_OSC_DIV 3
`define CMT_REG_TOP 16'h00FF
`define CMT_SFR_TOP 8'h17
`define CMT_SP_LO 8'h18
`define CMT_PORT3_ADDR 16'h1FFE
`define CMT_PORT4_ADDR 16'h1FFF
`define CMT_VEC_LO 16'h2000
`define CMT_VEC_HI 16'h2011
`define CMT_TEST_LO 16'h2012
`define CMT_TEST_HI 16'h2077
`define CMT_RESET_PC 16'h2080
`define CMT_ROM_LO 16'h2000
`define CMT_ROM_HI 16'h3FFF
`define CMT_NMI_ADDR 16'h0000
`define CMT_RELOAD_STATES 3'h4
`define CMT_RF_BYTES 232
`endif

// File: pkg/cmt_pkg.sv
// Purpose: Types for the core timing and memory-space decoder.
// Assumes: Included constants from cmt_map.svh.
// Notes: One-hot codes written out.
`default_nettype none
package cmt_pkg;
    typedef enum logic [2:0] {
        CMT_PH_A = 3'h1,
        CMT_PH_B = 3'h2,
        CMT_PH_C = 3'h4
    } cmt_phase_t;

    typedef enum logic [3:0] {
        CMT_TGT_REG = 4'h1,
        CMT_TGT_SFR = 4'h2,
        CMT_TGT_ROM = 4'h4,
        CMT_TGT_EXT = 4'h8
    } cmt_target_t;

    typedef enum logic [1:0] {
        CMT_SZ_BYTE = 2'h0,
        CMT_SZ_WORD = 2'h1,
        CMT_SZ_DWORD = 2'h2
    } cmt_size_t;

    typedef enum logic [3:0] {
        CMT_OP_ADD = 4'h0,
        CMT_OP_SUB = 4'h1,
        CMT_OP_AND = 4'h2,
        CMT_OP_OR = 4'h3,
        CMT_OP_XOR = 4'h4,
        CMT_OP_PASSA = 4'h5,
        CMT_OP_SHL = 4'h6,
        CMT_OP_SHR = 4'h7
    } cmt_op_t;

    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        cmt_size_t size;
        logic [15:0] addr;
        logic [31:0] wdata;
    } cmt_req_t;

    typedef struct packed {
        logic valid;
        cmt_target_t target;
        logic [15:0] addr;
        logic inst;
        logic port_slot;
        logic vector_slot;
        logic test_slot;
    } cmt_route_t;
endpackage
`default_nettype wire

// File: hdl/cmt_core.sv
// Purpose: Phase generator, address decoder, register file and datapath.
// Assumes: ref_clk is the oscillator; rst_n pin sampled by two flops.
// Notes: External bus cycle timing is handled outside this block.
`include "cmt_map.svh"
`timescale 1ns/100ps
`default_nettype none
module cmt_core
    import cmt_pkg::*;
#(
    parameter int RF_BYTES = `CMT_RF_BYTES,
    parameter bit ROM_FITTED = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rst_n_pin,
    input wire logic external_access_select,
    input wire logic nmi_req,
    input wire logic jump_req,
    input wire logic [15:0] jump_target,
    input wire logic advance_req,
    input wire cmt_req_t req,
    input wire cmt_op_t alu_op,
    input wire logic complement_b,
    input wire logic [7:0] a_reg_addr,
    input wire logic [7:0] b_reg_addr,
    input wire logic alu_write,
    input wire logic [4:0] loop_load,
    input wire logic loop_start,
    output logic phase_a_clock_output,
    output logic phase_b,
    output logic phase_c,
    output logic state_strobe,
    output cmt_route_t route,
    output logic [15:0] fetch_addr,
    output logic fetch_valid,
    output logic fetch_busy,
    output logic [15:0] program_counter,
    output logic [31:0] reg_rdata,
    output logic [15:0] stack_pointer,
    output logic [16:0] alu_result,
    output logic [7:0] a_bus,
    output logic [15:0] d_bus,
    output logic loop_busy,
    output logic [7:0] program_status_word
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_n_meta_reg;
    logic rst_n_sync_reg;
    logic soft_rst;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rst_n_meta_reg <= 1'b0;
            rst_n_sync_reg <= 1'b0;
        end else begin
            rst_n_meta_reg <= rst_n_pin;
            rst_n_sync_reg <= rst_n_meta_reg;
        end
    end

    // Two flops: the pin is asynchronous to ref_clk
    // Pin reset restarts the phase ring on a known edge
    assign soft_rst = ~rst_n_sync_reg;

    // ------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------
    cmt_phase_t phase_reg;
    cmt_phase_t phase_next;

    always_comb begin
        unique case (phase_reg)
            CMT_PH_A: phase_next = CMT_PH_B;
            CMT_PH_B: phase_next = CMT_PH_C;
            CMT_PH_C: phase_next = CMT_PH_A;
            default: phase_next = CMT_PH_A;
        endcase
    end

    // One-hot ring of three: divide by three, one-third duty
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= CMT_PH_A;
        end else if (soft_rst) begin
            phase_reg <= CMT_PH_A;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase_a_clock_output = phase_reg[0];
    assign phase_b = phase_reg[1];
    assign phase_c = phase_reg[2];
    // Datapath state advances once per state time, on phase C
    assign state_strobe = phase_reg[2] & ~soft_rst;

    // ------------------------------------------------------------
    // Address decoder
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic dec_reg_space;
    logic dec_rom_ok;
    logic dec_is_sfr;
    cmt_target_t dec_target;

    assign dec_reg_space = (req.addr <= `CMT_REG_TOP) && !req.fetch;
    assign dec_is_sfr = dec_reg_space && (req.addr[7:0] <= `CMT_SFR_TOP);
    // A part without ROM never claims the window
    assign dec_rom_ok = ROM_FITTED && external_access_select
        && in_range(req.addr, `CMT_ROM_LO, `CMT_ROM_HI);
    // Everything else is an external cycle, port slots included
    assign dec_target = dec_reg_space ? (dec_is_sfr ? CMT_TGT_SFR
        : CMT_TGT_REG) : (dec_rom_ok ? CMT_TGT_ROM : CMT_TGT_EXT);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            route <= '0;
        end else begin
            route.valid <= req.valid;
            route.target <= dec_target;
            route.addr <= req.addr;
            route.inst <= req.fetch;
            route.port_slot <= (req.addr == `CMT_PORT3_ADDR)
                || (req.addr == `CMT_PORT4_ADDR);
            route.vector_slot <= in_range(req.addr, `CMT_VEC_LO,
                `CMT_VEC_HI);
            // Fetch and data share this decode; only registers refuse fetches
            // Test area only internal; externally it is ordinary memory
            route.test_slot <= dec_rom_ok && in_range(req.addr,
                `CMT_TEST_LO, `CMT_TEST_HI);
        end
    end

    // ------------------------------------------------------------
    // Program counter and shadow fetch counter
    // ------------------------------------------------------------
    logic [15:0] pc_reg;
    logic [15:0] pc_inc;
    logic [15:0] shadow_reg;
    logic [2:0] reload_cnt_reg;
    logic reload_go;
    logic [15:0] reload_addr;

    // Separate incrementer; no ALU involvement for sequential flow
    assign pc_inc = pc_reg + 16'h0001;
    assign reload_go = state_strobe && (nmi_req || jump_req);
    // Jump targets arrive through the arithmetic result, not jump_target
    assign reload_addr = nmi_req ? `CMT_NMI_ADDR : alu_result[15:0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pc_reg <= `CMT_RESET_PC;
        end else if (soft_rst) begin
            pc_reg <= `CMT_RESET_PC;
        end else if (reload_go) begin
            pc_reg <= reload_addr;
        end else if (state_strobe && advance_req && reload_cnt_reg == 3'h0) begin
            pc_reg <= pc_inc;
        end
    end

    // Shadow stalls four state times after a reload
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shadow_reg <= `CMT_RESET_PC;
            reload_cnt_reg <= 3'h0;
        end else if (soft_rst) begin
            shadow_reg <= `CMT_RESET_PC;
            reload_cnt_reg <= 3'h0;
        end else if (reload_go) begin
            shadow_reg <= reload_addr;
            reload_cnt_reg <= `CMT_RELOAD_STATES;
        end else if (state_strobe && reload_cnt_reg != 3'h0) begin
            reload_cnt_reg <= reload_cnt_reg - 3'h1;
        end else if (state_strobe && advance_req) begin
            shadow_reg <= shadow_reg + 16'h0001;
        end
    end

    assign program_counter = pc_reg;
    assign fetch_addr = shadow_reg; // data requests never use it
    assign fetch_busy = reload_cnt_reg != 3'h0;
    assign fetch_valid = !fetch_busy && !soft_rst;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] rf_mem [0:RF_BYTES-1];
    logic [7:0] sfr_mem [0:23];
    logic rf_hit;
    logic [7:0] rf_idx;
    logic [7:0] a_idx;
    logic [7:0] b_idx;
    logic [15:0] a_word;
    logic [15:0] b_word;

    // Register file starts right after the special-function bytes
    assign rf_hit = req.valid && req.write && dec_target == CMT_TGT_REG;
    assign rf_idx = req.addr[7:0] - `CMT_SP_LO;
    assign a_idx = a_reg_addr - `CMT_SP_LO;
    assign b_idx = b_reg_addr - `CMT_SP_LO;

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] idx;
        idx = a - `CMT_SP_LO;
        if (a <= `CMT_SFR_TOP) begin
            rd_byte = sfr_mem[a[4:0]];
        end else begin
            rd_byte = rf_mem[idx];
        end
    endfunction

    // ------------------------------------------------------------
    // Byte lanes of a register-file access
    // ------------------------------------------------------------
    // Lane 0 is the addressed byte; wider sizes add the bytes above it
    function automatic logic lane_on(input cmt_size_t s,
                                     input logic [1:0] lane);
        unique case (s)
            CMT_SZ_BYTE: lane_on = lane == 2'h0;
            CMT_SZ_WORD: lane_on = lane <= 2'h1;
            CMT_SZ_DWORD: lane_on = 1'b1;
            default: lane_on = 1'b0;
        endcase
    endfunction

    logic [3:0] lane_en;

    // A size code outside the three legal ones writes no byte
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        assign lane_en[lane] = lane_on(req.size, 2'(lane));
    end

    // Byte, word and double-word writes; no check against the array end
    always_ff @(posedge ref_clk) begin
        if (rf_hit) begin
            if (lane_en[0]) begin
                rf_mem[rf_idx] <= req.wdata[7:0];
            end
            if (lane_en[1]) begin
                rf_mem[rf_idx + 8'h01] <= req.wdata[15:8];
            end
            if (lane_en[2]) begin
                rf_mem[rf_idx + 8'h02] <= req.wdata[23:16];
            end
            if (lane_en[3]) begin
                rf_mem[rf_idx + 8'h03] <= req.wdata[31:24];
            end
        end else if (alu_write && b_reg_addr > `CMT_SFR_TOP) begin
            // Result returns straight to a register; no accumulator
            rf_mem[b_idx] <= alu_result[7:0];
            rf_mem[b_idx + 8'h01] <= alu_result[15:8];
        end
        if (req.valid && req.write && dec_target == CMT_TGT_SFR) begin
            sfr_mem[req.addr[4:0]] <= req.wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (req.valid && !req.write && dec_reg_space) begin
            reg_rdata <= {rd_byte(req.addr[7:0] + 8'h03),
                rd_byte(req.addr[7:0] + 8'h02),
                rd_byte(req.addr[7:0] + 8'h01), rd_byte(req.addr[7:0])};
        end
    end

    // Stack pointer is the first word of the register file
    // Software must keep data out of it while the stack is in use
    assign stack_pointer = {rf_mem[1], rf_mem[0]};

    // ------------------------------------------------------------
    // Arithmetic unit and loop counter
    // ------------------------------------------------------------
    logic [16:0] op_a;
    logic [16:0] op_b;
    logic [16:0] alu_sum;
    logic [4:0] loop_reg;

    assign a_word = {rd_byte(a_reg_addr + 8'h01), rd_byte(a_reg_addr)};
    assign b_word = {rd_byte(b_reg_addr + 8'h01), rd_byte(b_reg_addr)};
    // Operands sign-extended to the 17-bit width
    assign op_a = {a_word[15], a_word};
    assign op_b = complement_b ? ~{b_word[15], b_word}
        : {b_word[15], b_word};
    assign alu_sum = op_a + op_b + {16'h0000, complement_b};

    always_comb begin
        unique case (alu_op)
            CMT_OP_ADD, CMT_OP_SUB: alu_result = alu_sum;
            CMT_OP_AND: alu_result = op_a & op_b;
            CMT_OP_OR: alu_result = op_a | op_b;
            CMT_OP_XOR: alu_result = op_a ^ op_b;
            CMT_OP_PASSA: alu_result = op_a;
            CMT_OP_SHL: alu_result = {op_a[15:0], 1'b0};
            CMT_OP_SHR: alu_result = {op_a[16], op_a[16:1]};
            default: alu_result = 17'h0_0000;
        endcase
    end

    // Counts one shift step per state time
    // A new load overrides a count still running
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loop_reg <= 5'h00;
        end else if (loop_start) begin
            loop_reg <= loop_load;
        end else if (state_strobe && loop_reg != 5'h00) begin
            loop_reg <= loop_reg - 5'h01;
        end
    end

    assign loop_busy = loop_reg != 5'h00;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            program_status_word <= 8'h00;
        end else if (alu_write) begin
            program_status_word <= {alu_result[16], alu_result[15],
                alu_result[15:0] == 16'h0000, 5'h00};
        end
    end

    // Narrow bus carries addresses; wide bus carries register data
    assign a_bus = reload_go ? reload_addr[7:0] : a_reg_addr;
    assign d_bus = a_word;

endmodule // cmt_core
`default_nettype wire

// File: bench/cmt_core_props.sv
// Purpose: Port assertions for cmt_core.
// Assumes: ROM_FITTED matches the bound core.
// Notes: The phase order rule waits until a pin reset has settled; the one-hot rule does not.
`timescale 1ns/100ps
`default_nettype none
module cmt_core_props
    import cmt_pkg::*;
#(
    parameter bit ROM_FITTED = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rst_n_pin,
    input wire logic external_access_select,
    input wire logic nmi_req,
    input wire logic jump_req,
    input wire cmt_req_t req,
    input wire logic phase_a_clock_output,
    input wire logic phase_b,
    input wire logic phase_c,
    input wire logic state_strobe,
    input wire cmt_route_t route,
    input wire logic [15:0] fetch_addr,
    input wire logic fetch_busy,
    input wire logic [15:0] program_counter
);
    // ------------------------------------------------------------
    // Settle counter: the pin reset goes through a synchroniser
    // ------------------------------------------------------------
    logic [2:0] settle_reg;
    logic ok, low, rom;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            settle_reg <= 3'h0;
        end else begin
            settle_reg <= rst_n_pin ? settle_reg +
                {2'h0, settle_reg != 3'h5} : 3'h0;
        end
    end
    assign ok = settle_reg == 3'h5 && rst_n_pin;
    assign low = req.addr <= 16'h00FF;
    assign rom = req.addr >= 16'h2000 && req.addr <= 16'h3FFF;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_phase_onehot: assert property (
        $onehot({phase_a_clock_output, phase_b, phase_c}))
        else $error("phase outputs not one-hot");
    chk_phase_order: assert property (
        ok && phase_a_clock_output && state_strobe == phase_c |=>
        phase_b ##1 phase_c ##1 phase_a_clock_output)
        else $error("phase sequence broken");
    chk_reg_data: assert property (
        req.valid && !req.fetch && low |=> route.target ==
        ($past(req.addr) <= 16'h0017 ? CMT_TGT_SFR : CMT_TGT_REG))
        else $error("low data access misrouted");
    chk_fetch_low: assert property (
        req.valid && req.fetch && low |=>
        route.target == CMT_TGT_EXT && route.inst)
        else $error("low fetch not external");
    chk_rom_gate: assert property (
        req.valid && rom && external_access_select |=>
        route.target == (ROM_FITTED ? CMT_TGT_ROM : CMT_TGT_EXT))
        else $error("rom window misrouted");
    chk_ext_rest: assert property (
        req.valid && !low && !(rom && external_access_select) |=>
        route.target == CMT_TGT_EXT)
        else $error("external access misrouted");
    chk_reload_len: assert property (
        ok && state_strobe && (jump_req || nmi_req) && !fetch_busy |=>
        fetch_busy [*6] ##1 fetch_busy [*6] ##1 !fetch_busy)
        else $error("reload length wrong");
    chk_reset_entry: assert property (
        $fell(rst) |-> program_counter == 16'h2080 &&
        fetch_addr == 16'h2080)
        else $error("reset entry address wrong");
endmodule // cmt_core_props
`default_nettype wire

// File: bench/cmt_ext_mem.sv
// Purpose: External memory beyond the decoder.
// Assumes: One word answers each external route.
// Notes: Idle bus toggles so no stale word passes.
`timescale 1ns/100ps
`default_nettype none
module cmt_ext_mem
    import cmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire cmt_route_t route,
    output logic [15:0] ext_rdata
);
    // ------------------------------------------------------------
    // Memory answer
    // ------------------------------------------------------------
    logic [15:0] data_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_reg <= 16'h0000;
        end else if (route.valid && route.target == CMT_TGT_EXT) begin
            data_reg <= route.addr ^ 16'hA5A5;
        end else begin
            data_reg <= ~data_reg;
        end
    end
    assign ext_rdata = data_reg;
endmodule // cmt_ext_mem
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for cmt_core.
// Assumes: Route and read data appear one clock after a request.
// Notes: Four unused inputs are tied off.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import cmt_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, checks and tests
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic rst_n_pin = 1'b1;
    logic ea = 1'b0;
    logic nmi_req = 1'b0;
    logic jump_req = 1'b0;
    logic adv = 1'b0;
    logic [15:0] dbus;
    cmt_req_t req = '0;
    cmt_op_t alu_op = CMT_OP_ADD;
    logic cb = 1'b0;
    logic [7:0] a_ra = 8'h00;
    logic [7:0] b_ra = 8'h00;
    logic ph_a, ph_b, ph_c, strobe, busy;
    cmt_route_t route;
    logic [15:0] fa, pc, sp, ext_rdata;
    logic [31:0] rdata;
    logic [16:0] alu_res;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [15:0] corners [14] = '{16'h0000, 16'h0017, 16'h0018,
        16'h00FF, 16'h0100, 16'h1FFD, 16'h1FFE, 16'h1FFF, 16'h2000,
        16'h2011, 16'h2077, 16'h2080, 16'h3FFF, 16'h4000};
    cmt_op_t ops [8] = '{CMT_OP_ADD, CMT_OP_AND, CMT_OP_OR,
        CMT_OP_XOR, CMT_OP_PASSA, CMT_OP_SUB, CMT_OP_SHL, CMT_OP_SHR};
    always #12.5 ref_clk = ~ref_clk;
    cmt_core u_cmt_core (
        .ref_clk(ref_clk), .rst(rst), .rst_n_pin(rst_n_pin),
        .external_access_select(ea), .nmi_req(nmi_req),
        .jump_req(jump_req), .jump_target(16'h0000), .advance_req(adv),
        .req(req), .alu_op(alu_op), .complement_b(cb),
        .a_reg_addr(a_ra), .b_reg_addr(b_ra), .alu_write(1'b0),
        .loop_load(5'h00), .loop_start(1'b0),
        .phase_a_clock_output(ph_a), .phase_b(ph_b), .phase_c(ph_c),
        .state_strobe(strobe), .route(route), .fetch_addr(fa),
        .fetch_valid(), .fetch_busy(busy), .program_counter(pc),
        .reg_rdata(rdata), .stack_pointer(sp), .alu_result(alu_res),
        .a_bus(), .d_bus(dbus), .loop_busy(), .program_status_word());
    cmt_ext_mem u_cmt_ext_mem (.ref_clk(ref_clk), .rst(rst),
        .route(route), .ext_rdata(ext_rdata));
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    function automatic logic in_rng(input logic [15:0] a, lo, hi);
        return a >= lo && a <= hi;
    endfunction
    function automatic cmt_target_t exp_tgt(input logic f, e,
                                            input logic [15:0] a);
        if (!f && a <= 16'h00FF) begin
            return (a <= 16'h0017) ? CMT_TGT_SFR : CMT_TGT_REG;
        end
        return (e && in_rng(a, 16'h2000, 16'h3FFF)) ? CMT_TGT_ROM
                                                    : CMT_TGT_EXT;
    endfunction
    task automatic access(input logic f, w, input cmt_size_t s,
                          input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, f, w, s, a, d};
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
    endtask
    task automatic decode(input logic f, e, input logic [15:0] a);
        cmt_target_t t;
        t = exp_tgt(f, e, a);
        @(posedge ref_clk);
        ea <= e;
        access(f, 1'b0, CMT_SZ_BYTE, a, 32'h0);
        check("target", route.target, t);
        check("inst", route.inst, f);
        check("port slot", route.port_slot, a[15:1] == 15'h0FFF);
        check("vector", route.vector_slot, in_rng(a, 16'h2000, 16'h2011));
        check("test", route.test_slot, e && in_rng(a, 16'h2012, 16'h2077));
        if (t == CMT_TGT_EXT) begin
            tick();
            check("ext data", ext_rdata, a ^ 16'hA5A5);
        end
    endtask
    task automatic reload(input logic nmi);
        int n;
        n = 0;
        tick();
        while (!ph_b) tick();
        @(posedge ref_clk);
        nmi_req <= nmi;
        jump_req <= !nmi;
        @(posedge ref_clk);
        nmi_req <= 1'b0;
        jump_req <= 1'b0;
        #1;
        while (busy && n < 40) begin
            tick();
            n++;
        end
        check("reload", n, 12);
        if (nmi) check("nmi target", fa, 16'h0000);
    endtask
    initial begin
        logic [2:0] prev;
        logic [15:0] a, x, y;
        logic [31:0] d;
        int n;
        void'($urandom(32'h4d6c));
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) tick();
        n = 0;
        repeat (30) begin
            prev = {ph_c, ph_b, ph_a};
            tick();
            check("phase", {ph_c, ph_b, ph_a}, {prev[1:0], prev[2]});
            check("strobe", strobe, ph_c);
            n += ph_a;
        end
        check("phase a count", n, 10);
        $display("phase test done");
        foreach (corners[i]) begin
            for (int k = 0; k < 4; k++) decode(k[0], k[1], corners[i]);
        end
        repeat (200) decode(1'($urandom), 1'($urandom), 16'($urandom));
        $display("decode test done");
        repeat (30) begin
            a = {8'h00, 6'($urandom_range(62, 7)), 2'b00};
            d = $urandom;
            access(1'b0, 1'b1, CMT_SZ_DWORD, a, d);
            access(1'b0, 1'b0, CMT_SZ_DWORD, a, 32'h0);
            check("dword", rdata, d);
            access(1'b0, 1'b0, CMT_SZ_BYTE, a + 16'h1, 32'h0);
            check("byte", rdata[7:0], d[15:8]);
        end
        access(1'b0, 1'b1, CMT_SZ_WORD, 16'h0018, d);
        check("stack pointer", sp, d[15:0]);
        repeat (20) begin
            x = $urandom;
            y = $urandom;
            access(1'b0, 1'b1, CMT_SZ_WORD, 16'h0040, {16'h0, x});
            access(1'b0, 1'b1, CMT_SZ_WORD, 16'h0042, {16'h0, y});
            n = $urandom_range(7, 0);
            @(posedge ref_clk);
            alu_op <= ops[n];
            cb <= n[0];
            a_ra <= 8'h40;
            b_ra <= 8'h42;
            tick();
            y = n[0] ? ~y : y;
            d = {15'h0, x + y};
            d = (n == 1) ? x & y : (n == 2) ? x | y : (n == 3) ? x ^ y :
                (n == 4) ? {16'h0, x} : d;
            d = (n == 5) ? {16'h0, x + y + 16'h0001} :
                (n == 6) ? {16'h0, x[14:0], 1'b0} :
                (n == 7) ? {16'h0, x[15], x[15:1]} : d;
            check("alu", alu_res[15:0], d[15:0]);
            check("d bus", dbus, x);
        end
        $display("register and alu test done");
        repeat (3) reload(1'b1);
        repeat (3) reload(1'b0);
        x = pc;
        @(posedge ref_clk);
        adv <= 1'b1;
        repeat (3) @(posedge ref_clk);
        adv <= 1'b0;
        #1;
        check("pc step", pc, x + 16'h0001);
        check("shadow step", fa, x + 16'h0001);
        $display("reload test done");
        tick();
        while (!ph_b) tick();
        @(posedge ref_clk);
        rst_n_pin <= 1'b0;
        repeat (5) tick();
        check("held phase", ph_a, 1'b1);
        check("pin reset pc", pc, 16'h2080);
        @(posedge ref_clk);
        rst_n_pin <= 1'b1;
        n = 0;
        do begin
            tick();
            n++;
        end while (!ph_b && n < 10);
        check("restart edges", n, 3);
        $display("pin reset test done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end
endmodule // tb_top
bind cmt_core cmt_core_props #(.ROM_FITTED(ROM_FITTED)) u_cmt_core_props (
    .ref_clk(ref_clk), .rst(rst), .rst_n_pin(rst_n_pin),
    .external_access_select(external_access_select), .nmi_req(nmi_req),
    .jump_req(jump_req), .req(req),
    .phase_a_clock_output(phase_a_clock_output), .phase_b(phase_b),
    .phase_c(phase_c), .state_strobe(state_strobe), .route(route),
    .fetch_addr(fetch_addr), .fetch_busy(fetch_busy),
    .program_counter(program_counter));
`default_nettype wire
